// File: flags_params.svh
`ifndef FLAGS_PARAMS_SVH
`define FLAGS_PARAMS_SVH
`define FLAGS_ADDR_LO      8'h03
`define FLAGS_ADDR_HI      8'h83
`define BIT_CARRY          0
`define BIT_NIBBLE         1
`define BIT_NIL            2
`define BIT_SLEEP          3
`define BIT_WDOG           4
`define BIT_BANK_LO        5
`define BIT_BANK_HI        6
`define BIT_IND_HI         7
`define FLAGS_RESET        8'h18
`define BANK_ADDR_BIT      7
`endif

// File: flags_pkg.sv
package flags_pkg;
  typedef enum logic [3:0] {
    op_none,
    op_add_w_file,
    op_add_literal,
    op_sub_literal,
    op_sub_w_file,
    op_logic,
    op_rotate_right,
    op_rotate_left,
    op_zero_fill,
    op_move_w_to_file,
    op_bit_clear,
    op_bit_set,
    op_nibble_swap
  } alu_op_e;
endpackage

// File: core_flags_word.sv
`timescale 1ns/10ps
`include "flags_params.svh"
module core_flags_word
  import flags_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       exec_en,
  input  wire alu_op_e    alu_op,
  input  wire logic [7:0] operand_w,
  input  wire logic [7:0] operand_f,
  input  wire logic [2:0] bit_sel,
  input  wire logic [6:0] dir_addr,
  input  wire logic       dest_file,
  input  wire logic       wdog_expired_set,
  input  wire logic       sleep_entered_set,
  input  wire logic       flags_restore,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic      [7:0] alu_result,
  output logic      [7:0] eff_addr,
  output logic            flags_dest
);
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] rdata;
    logic [7:0] result;
  } state_s;

  state_s st_q;
  state_s st_d;

  function automatic logic is_flags_addr(input logic [7:0] a);
    is_flags_addr = (a == `FLAGS_ADDR_LO) || (a == `FLAGS_ADDR_HI);
  endfunction

  // add and subtract share the nibble and carry chain
  function automatic logic is_add_sub(input alu_op_e op);
    is_add_sub = (op == op_add_w_file) || (op == op_add_literal) ||
                 (op == op_sub_literal) || (op == op_sub_w_file);
  endfunction

  // one-hot mask for the bit instructions
  function automatic logic [7:0] bit_mask(input logic [2:0] sel);
    bit_mask = 8'h01 << sel;
  endfunction

  logic [7:0] full_addr;
  logic [8:0] sum;
  logic [4:0] nib_sum;
  logic [7:0] res;
  logic       touches_arith;
  logic       touches_carry;
  logic       new_carry;
  logic       new_nibble;
  logic       writes_dest;
  logic       status_free;
  logic       port_hit;
  logic [7:0] base_flags;
  logic [7:0] port_merge;
  logic [7:0] dest_merge;

  // bank bit forms the top address bit for direct accesses
  assign full_addr = {st_q.flags[`BIT_BANK_LO], dir_addr};
  assign flags_dest = is_flags_addr(full_addr) && dest_file;
  assign port_hit    = reg_wr && is_flags_addr(reg_addr);
  assign status_free = !(touches_arith || touches_carry);
  assign base_flags  = port_hit ? port_merge : st_q.flags;

  // per-bit merge of port writes and destination writes into the word
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_merge
      if (gi == `BIT_WDOG || gi == `BIT_SLEEP)
      begin : g_ro
        // only the hardware event inputs move these two bits
        assign port_merge[gi] = st_q.flags[gi];
        assign dest_merge[gi] = base_flags[gi];
      end
      else if (gi >= `BIT_BANK_LO)
      begin : g_upper
        assign port_merge[gi] = reg_wdata[gi];
        assign dest_merge[gi] = res[gi];
      end
      else
      begin : g_status
        // any status-affecting op locks all three arithmetic bits
        assign port_merge[gi] = reg_wdata[gi];
        assign dest_merge[gi] = status_free ? res[gi] : base_flags[gi];
      end
    end
  endgenerate

  always_comb
  begin
    sum           = 9'h000;
    nib_sum       = 5'h00;
    res           = 8'h00;
    touches_arith = 1'b0;
    touches_carry = 1'b0;
    new_carry     = 1'b0;
    new_nibble    = 1'b0;
    writes_dest   = 1'b1;
    unique case (alu_op)
      op_add_w_file, op_add_literal:
      begin
        sum           = {1'b0, operand_f} + {1'b0, operand_w};
        nib_sum       = {1'b0, operand_f[3:0]} + {1'b0, operand_w[3:0]};
        res           = sum[7:0];
        touches_arith = 1'b1;
        touches_carry = 1'b1;
        new_carry     = sum[8];
        new_nibble    = nib_sum[4];
      end
      op_sub_literal, op_sub_w_file:
      begin
        // two's complement add gives carry = not borrow directly
        sum     = {1'b0, operand_f} + {1'b0, ~operand_w} + 9'h001;
        nib_sum = {1'b0, operand_f[3:0]} + {1'b0, ~operand_w[3:0]} + 5'h01;
        res           = sum[7:0];
        touches_arith = 1'b1;
        touches_carry = 1'b1;
        new_carry     = sum[8];
        new_nibble    = nib_sum[4];
      end
      op_logic:
      begin
        res           = operand_f & operand_w;
        touches_arith = 1'b1;
      end
      op_rotate_right:
      begin
        res           = {st_q.flags[`BIT_CARRY], operand_f[7:1]};
        touches_carry = 1'b1;
        new_carry     = operand_f[0];
      end
      op_rotate_left:
      begin
        res           = {operand_f[6:0], st_q.flags[`BIT_CARRY]};
        touches_carry = 1'b1;
        new_carry     = operand_f[7];
      end
      op_zero_fill:
      begin
        res           = 8'h00;
        touches_arith = 1'b1;
      end
      op_move_w_to_file:
      begin
        res = operand_w;
      end
      op_bit_clear:
      begin
        res = operand_f & ~bit_mask(bit_sel);
      end
      op_bit_set:
      begin
        res = operand_f | bit_mask(bit_sel);
      end
      op_nibble_swap:
      begin
        res = {operand_f[3:0], operand_f[7:4]};
      end
      op_none:
      begin
        writes_dest = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    st_d        = st_q;
    st_d.rdata  = 8'h00;
    if (reg_rd && is_flags_addr(reg_addr))
    begin
      st_d.rdata = st_q.flags;
    end
    if (port_hit)
    begin
      // port writes skip the arithmetic masking; bits 4 and 3 stay put
      st_d.flags = base_flags;
    end
    if (exec_en)
    begin
      st_d.result = res;
      if (flags_dest && writes_dest)
      begin
        // exec wins over a same-cycle port write, except in status bits the op locks but does not update
        st_d.flags = dest_merge;
      end
      if (touches_arith)
      begin
        st_d.flags[`BIT_NIL] = (res == 8'h00);
      end
      if (touches_carry)
      begin
        st_d.flags[`BIT_CARRY] = new_carry;
      end
      if (is_add_sub(alu_op))
      begin
        st_d.flags[`BIT_NIBBLE] = new_nibble;
      end
    end
    // hardware events are the only way to move these two bits
    if (flags_restore)
    begin
      st_d.flags[`BIT_WDOG]  = 1'b1;
      st_d.flags[`BIT_SLEEP] = 1'b1;
    end
    if (wdog_expired_set)
    begin
      st_d.flags[`BIT_WDOG] = 1'b0;
    end
    if (sleep_entered_set)
    begin
      st_d.flags[`BIT_SLEEP] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= {`FLAGS_RESET, 8'h00, 8'h00};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign reg_rdata  = st_q.rdata;
  assign alu_result = st_q.result;
  assign eff_addr   = full_addr;
endmodule // core_flags_word

// File: core_flags_word_assertions.sv
`timescale 1ns/10ps
module core_flags_word_assertions
  import flags_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       exec_en,
  input wire alu_op_e    alu_op,
  input wire logic [7:0] operand_w,
  input wire logic [7:0] operand_f,
  input wire logic [6:0] dir_addr,
  input wire logic       dest_file,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] alu_result,
  input wire logic [7:0] eff_addr,
  input wire logic       flags_dest
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  AST_RD_ZERO: assert property (
    (!reg_rd || reg_addr[6:0] != 7'h03) |=> reg_rdata == 8'h00)
    else $error("read data not zero");
  AST_EFF_LO: assert property (eff_addr[6:0] == dir_addr)
    else $error("direct address low bits wrong");
  AST_BANK: assert property (
    reg_wr && (reg_addr == 8'h03 || reg_addr == 8'h83) && !exec_en
    |=> eff_addr[7] == $past(reg_wdata[5]))
    else $error("bank select not applied");
  AST_DEST: assert property (
    flags_dest == (dest_file && eff_addr[6:0] == 7'h03))
    else $error("flags destination wrong");
  AST_ADD: assert property (
    exec_en && alu_op == op_add_w_file
    |=> alu_result == $past(operand_w + operand_f))
    else $error("add result wrong");
  AST_SUB: assert property (
    exec_en && alu_op == op_sub_w_file
    |=> alu_result == $past(operand_f - operand_w))
    else $error("subtract result wrong");
  AST_RLF: assert property (
    exec_en && alu_op == op_rotate_left
    |=> alu_result[7:1] == $past(operand_f[6:0]))
    else $error("rotate result wrong");
  AST_AND: assert property (
    exec_en && alu_op == op_logic
    |=> alu_result == $past(operand_w & operand_f))
    else $error("logic result wrong");
  COV_ADD: cover property (exec_en && alu_op == op_add_w_file);
  COV_WR: cover property (reg_wr && reg_addr[6:0] == 7'h03);
  COV_DEST: cover property (exec_en && flags_dest);
endmodule // core_flags_word_assertions
bind core_flags_word core_flags_word_assertions
  core_flags_word_assertions_inst (.*);

// File: tb.sv
`timescale 1ns/10ps
module tb;
  import flags_pkg::*;
  logic       clk = 0, resetn = 0, exec_en = 0, dest_file = 0;
  logic       reg_wr = 0, reg_rd = 0, flags_dest;
  logic       wdog_expired_set = 0, sleep_entered_set = 0;
  logic       flags_restore = 0;
  alu_op_e    alu_op = op_none;
  logic [7:0] operand_w = 0, operand_f = 0, reg_addr = 0, reg_wdata = 0;
  logic [7:0] reg_rdata, alu_result, eff_addr;
  logic [6:0] dir_addr = 7'h03;
  logic [2:0] bit_sel = 0;
  int         n_mismatch = 0, checks_done = 0;
  always #25 clk = ~clk;
  core_flags_word core_flags_word_inst (.*);
  task cmp(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error %0s expected %h seen %h", n, e, g);
    end
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp("flags", e, reg_rdata);
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // flags are read back through the port after each instruction
  task ex(input alu_op_e op, input logic [7:0] w, f, input logic d,
          input logic [7:0] e);
    @(posedge clk);
    exec_en <= 1'b1;
    alu_op <= op;
    operand_w <= w;
    operand_f <= f;
    dest_file <= d;
    @(posedge clk);
    exec_en <= 1'b0;
    rd(8'h03, e);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h03, 8'h18);
    wr(8'h03, 8'h27);
    rd(8'h83, 8'h3f);
    rd(8'h03, 8'h3f);
    cmp("bank", 8'h83, eff_addr);
    rd(8'h04, 8'h00);
    $display("test registers done");
    ex(op_zero_fill, 8'h55, 8'h3f, 1'b1, 8'h1f);
    ex(op_add_w_file, 8'h0f, 8'h01, 1'b0, 8'h1a);
    ex(op_add_w_file, 8'hff, 8'h01, 1'b0, 8'h1f);
    ex(op_sub_w_file, 8'h01, 8'h10, 1'b0, 8'h19);
    ex(op_add_w_file, 8'h20, 8'h19, 1'b1, 8'h38);
    ex(op_rotate_left, 8'h00, 8'h81, 1'b0, 8'h39);
    cmp("result", 8'h02, alu_result);
    ex(op_logic, 8'h0f, 8'hf0, 1'b0, 8'h3d);
    ex(op_logic, 8'hff, 8'h22, 1'b1, 8'h39);
    cmp("result", 8'h22, alu_result);
    ex(op_rotate_right, 8'h00, 8'h02, 1'b0, 8'h38);
    cmp("result", 8'h81, alu_result);
    ex(op_sub_literal, 8'h05, 8'h05, 1'b0, 8'h3f);
    ex(op_add_literal, 8'h08, 8'h08, 1'b0, 8'h3a);
    $display("test alu done");
    ex(op_move_w_to_file, 8'h05, 8'h3a, 1'b1, 8'h1d);
    @(posedge clk);
    bit_sel <= 3'h5;
    ex(op_bit_set, 8'h00, 8'h1d, 1'b1, 8'h3d);
    ex(op_bit_clear, 8'h00, 8'h3d, 1'b1, 8'h1d);
    ex(op_nibble_swap, 8'h00, 8'h03, 1'b1, 8'h38);
    ex(op_none, 8'h00, 8'h00, 1'b1, 8'h38);
    cmp("dest", 8'h01, {7'h00, flags_dest});
    @(posedge clk);
    dir_addr <= 7'h05;
    ex(op_move_w_to_file, 8'h00, 8'h38, 1'b1, 8'h38);
    cmp("dest", 8'h00, {7'h00, flags_dest});
    cmp("addr", 8'h85, eff_addr);
    $display("test destination done");
    @(posedge clk);
    wdog_expired_set <= 1'b1;
    flags_restore <= 1'b1;
    @(posedge clk);
    wdog_expired_set <= 1'b0;
    flags_restore <= 1'b0;
    rd(8'h03, 8'h28);
    @(posedge clk);
    sleep_entered_set <= 1'b1;
    @(posedge clk);
    sleep_entered_set <= 1'b0;
    rd(8'h83, 8'h20);
    @(posedge clk);
    flags_restore <= 1'b1;
    @(posedge clk);
    flags_restore <= 1'b0;
    rd(8'h03, 8'h38);
    $display("test watchdog done");
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h83, 8'h18);
    cmp("result", 8'h00, alu_result);
    cmp("addr", 8'h05, eff_addr);
    $display("test reset done");
    finish_test;
  end
endmodule // tb
